/* File: design/lcp_top.sv */
// Network command port front end: control codes, port lock, connection limits,
// network triggers, discovery answers and the standard event status registers.
// Assumes a network stack on the same clock that delivers decoded characters and events.
`timescale 1ns/1ps
`include "lcp_params.svh"

// What this block does
// - Web port accepts at most eight connections, refuses any more.
// - CR or LF ends a command line on telnet and raw ports, starting parse.
// - Raw port never echoes characters and never sends a prompt.
// - 0x01 closes, 0x02 triggers with acknowledge, 0x03 device-clears with acknowledge.
// - 0x05 answers with the user description string.
// - 0x12 grants exclusive lock if other two ports unused; 0x14 unlocks.
// - Lock request answered with denied or granted message.
// - VXI-11 listening port always open; at most two VXI-11 connections.
// - Each VXI-11 session gets two further assigned ports on open.
// - VXI-11 client takes lock first; other VXI-11 sessions then denied control.
// - Trigger port accepts multicast or TCP trigger events.
// - Only trigger domain 1 with the fixed name is recognised.
// - Armed trigger changes output within 2.5 ms of the request.
// - Discovery port answers UDP broadcast, only the GETPORT procedure.
// - Discovery over TCP also supports only GETPORT.
// - Clear status zeroes event, operation, questionable, status byte, error queue; masks kept.
// - Enable mask written as 0 to 255, zero after reset.
// - Event summary bit set when status AND mask is nonzero.
// - Shared layout: bits 7,5,4,3,2,0 used; bits 6 and 1 unused.
// - Enable mask query returns stored mask unchanged.
// - Event status query returns contents then clears it.
// - Error ranges 100,200,300,400 set bits 5,4,3,2 respectively.
// - After operation complete command, bit 0 set once pending work ends.
module lcp_top #(
	parameter int WEB_MAX = 8,
	parameter int VXI_MAX = 2,
	parameter logic [15:0] VXI_PORT_BASE = 16'h0800,
	parameter logic [31:0] FIXED_TRIGGER_NAME = 32'h4C414E30,
	parameter logic [31:0] CORE_PROG = 32'h00000001, // arbitrary program number
	parameter int TRIG_DEADLINE_CYC = int'(`LCP_TRIG_DEADLINE_US * 1000.0 * `LCP_CLK_MHZ) / 1000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire lcp_pkg::lcp_char_t [2:0] rx_char,
	input wire logic [2:0] conn_open,
	input wire logic [2:0] conn_close,
	input wire logic vxi_sess,
	output lcp_pkg::lcp_char_t [2:0] echo_char,
	output lcp_pkg::lcp_char_t [2:0] parse_char,
	output logic [2:0] line_end,
	output lcp_pkg::lcp_rsp_t [2:0] rsp_code,
	output logic [2:0] drop_conn,
	output logic [1:0] lock_owner,
	output logic [2:0] ctl_ok,
	output logic dev_clear,
	input wire logic web_open,
	input wire logic web_close,
	output logic web_accept,
	output logic web_refuse,
	input wire logic vxi_open,
	input wire logic vxi_close,
	input wire logic vxi_close_sess,
	output logic vxi_listen,
	output logic vxi_accept,
	output logic vxi_refuse,
	output logic vxi_new_sess,
	output logic [15:0] vxi_core_port,
	output logic [15:0] vxi_async_port,
	input wire logic trg_valid,
	input wire logic trg_tcp,
	input wire logic [7:0] trg_domain,
	input wire logic [31:0] trg_name,
	input wire logic trg_armed,
	input wire logic out_ready,
	output logic trig_fire,
	input wire logic rpc_valid,
	input wire logic rpc_tcp,
	input wire logic [7:0] rpc_proc,
	input wire logic [31:0] rpc_prog,
	output logic rpc_done,
	output logic rpc_ok,
	output logic rpc_tcp_ans,
	output logic [15:0] rpc_port,
	input wire lcp_pkg::lcp_st_cmd_t st_cmd,
	input wire logic err_valid,
	input wire logic [9:0] err_code,
	input wire logic ops_busy,
	output logic st_rsp_valid,
	output logic [7:0] st_rsp_data,
	output logic event_summary_bit,
	output logic cls_pulse
);

	initial begin
		if (WEB_MAX < 1 || WEB_MAX > 15) $error("WEB_MAX out of range");
		if (VXI_MAX != 2) $error("VXI_MAX must be two, one slot per session id");
		if (TRIG_DEADLINE_CYC < 1) $error("TRIG_DEADLINE_CYC must be positive");
	end

	////////////////////////////////////////////////////////////////////////////
	// Control code decode and port lock

	// True when a character terminates a command line
	function automatic logic is_term(input logic [7:0] c);
		return c == `LCP_CODE_CR || c == `LCP_CODE_LF;
	endfunction : is_term

	// True when a character is an in-band control code
	function automatic logic is_ctl(input logic [7:0] c);
		return c == `LCP_CODE_CLOSE || c == `LCP_CODE_TRIG || c == `LCP_CODE_CLEAR ||
			c == `LCP_CODE_ENQ || c == `LCP_CODE_LOCK || c == `LCP_CODE_UNLOCK;
	endfunction : is_ctl

	logic [2:0] open_r;
	logic [1:0] lock_vxi_r; // Session id of the VXI holder
	logic [2:0] lock_req;
	logic [2:0] lock_free;
	logic [2:0] rel_req;

	// Request and release conditions per port
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			lock_req[p] = rx_char[p].valid && rx_char[p].data == `LCP_CODE_LOCK;
			lock_free[p] = 1'b1;
			for (int q = 0; q < 3; q++) begin
				if (q != p && open_r[q]) lock_free[p] = 1'b0;
			end
			if (lock_owner != `LCP_OWNER_NONE && lock_owner != 2'(p)) lock_free[p] = 1'b0;
			rel_req[p] = lock_owner == 2'(p) && (conn_close[p] || drop_conn[p] ||
				(rx_char[p].valid && rx_char[p].data == `LCP_CODE_UNLOCK));
		end
	end

	// Connection open flags of the three command ports
	always_ff @(posedge clk) begin
		if (!rstn) begin
			open_r <= 3'h0;
		end else begin
			open_r <= (open_r | conn_open) & ~conn_close & ~drop_conn;
		end
	end

	// Lock owner; lowest port wins if two ask in one cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			lock_owner <= `LCP_OWNER_NONE;
			lock_vxi_r <= 2'h0;
		end else if (|rel_req) begin
			lock_owner <= `LCP_OWNER_NONE;
		end else if (lock_owner == `LCP_OWNER_NONE) begin
			for (int p = 2; p >= 0; p--) begin
				if (lock_req[p] && lock_free[p]) begin
					lock_owner <= 2'(p);
					lock_vxi_r <= {1'b0, vxi_sess};
				end
			end
		end
	end

	// Control access: unlocked means everyone; VXI holder excludes the other session
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ctl_ok <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				ctl_ok[p] <= lock_owner == `LCP_OWNER_NONE || lock_owner == 2'(p);
			end
			if (lock_owner == `LCP_PORT_VXI && vxi_sess != lock_vxi_r[0]) ctl_ok[2] <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Per-port character handling

	// Echo, parse forwarding, line ends, answers and drops
	always_ff @(posedge clk) begin
		if (!rstn) begin
			echo_char <= '0;
			parse_char <= '0;
			line_end <= 3'h0;
			rsp_code <= {3{lcp_pkg::RSP_NONE}};
			drop_conn <= 3'h0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				echo_char[p] <= '0;
				parse_char[p] <= '0;
				line_end[p] <= 1'b0;
				rsp_code[p] <= lcp_pkg::RSP_NONE;
				drop_conn[p] <= 1'b0;
				if (rx_char[p].valid) begin
					unique case (rx_char[p].data)
						`LCP_CODE_CLOSE: drop_conn[p] <= 1'b1;
						`LCP_CODE_TRIG: rsp_code[p] <= lcp_pkg::RSP_TRIG_ACK;
						`LCP_CODE_CLEAR: rsp_code[p] <= lcp_pkg::RSP_CLEAR_ACK;
						`LCP_CODE_ENQ: rsp_code[p] <= lcp_pkg::RSP_DESCR;
						`LCP_CODE_LOCK: begin
							rsp_code[p] <= (lock_free[p] && lock_owner == `LCP_OWNER_NONE && !(|rel_req))
								? lcp_pkg::RSP_GRANTED : lcp_pkg::RSP_DENIED;
						end
						default: begin
							if (is_term(rx_char[p].data)) begin
								line_end[p] <= 1'b1;
								if (2'(p) == `LCP_PORT_TELNET) rsp_code[p] <= lcp_pkg::RSP_PROMPT;
							end else if (!is_ctl(rx_char[p].data)) begin
								parse_char[p] <= rx_char[p];
							end
							// Only telnet echoes; raw stays silent even behind a telnet client
							if (2'(p) == `LCP_PORT_TELNET && !is_term(rx_char[p].data)) begin
								echo_char[p] <= rx_char[p];
							end
						end
					endcase
				end
			end
		end
	end

	// Trigger and device clear pulses shared by all command ports
	logic [2:0] code_trig;
	logic [2:0] code_clear;
	always_comb begin
		for (int p = 0; p < 3; p++) begin
			code_trig[p] = rx_char[p].valid && rx_char[p].data == `LCP_CODE_TRIG;
			code_clear[p] = rx_char[p].valid && rx_char[p].data == `LCP_CODE_CLEAR;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			dev_clear <= 1'b0;
		end else begin
			dev_clear <= |code_clear;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Web and VXI-11 connection limits

	logic [3:0] web_cnt_r;
	logic [1:0] vxi_slot_r;

	// Web connection count, refusing beyond the limit
	always_ff @(posedge clk) begin
		if (!rstn) begin
			web_cnt_r <= 4'h0;
			web_accept <= 1'b0;
			web_refuse <= 1'b0;
		end else begin
			web_accept <= web_open && web_cnt_r < 4'(WEB_MAX);
			web_refuse <= web_open && web_cnt_r >= 4'(WEB_MAX);
			if (web_open && web_cnt_r < 4'(WEB_MAX) && !(web_close && web_cnt_r != 4'h0)) begin
				web_cnt_r <= web_cnt_r + 4'h1;
			end else if (web_close && web_cnt_r != 4'h0 && !(web_open && web_cnt_r < 4'(WEB_MAX))) begin
				web_cnt_r <= web_cnt_r - 4'h1;
			end
		end
	end

	// VXI-11 slots; each opened session gets two ports of its own
	always_ff @(posedge clk) begin
		if (!rstn) begin
			vxi_slot_r <= 2'h0;
			vxi_listen <= 1'b0;
			vxi_accept <= 1'b0;
			vxi_refuse <= 1'b0;
			vxi_new_sess <= 1'b0;
			vxi_core_port <= 16'h0000;
			vxi_async_port <= 16'h0000;
		end else begin
			vxi_listen <= 1'b1;
			vxi_accept <= 1'b0;
			vxi_refuse <= 1'b0;
			if (vxi_close) vxi_slot_r[vxi_close_sess] <= 1'b0;
			if (vxi_open) begin
				if (!vxi_slot_r[0] || !vxi_slot_r[1]) begin
					vxi_accept <= 1'b1;
					vxi_new_sess <= vxi_slot_r[0];
					vxi_slot_r[vxi_slot_r[0]] <= 1'b1;
					vxi_core_port <= VXI_PORT_BASE + {14'h0000, vxi_slot_r[0], 1'b0};
					vxi_async_port <= VXI_PORT_BASE + {14'h0000, vxi_slot_r[0], 1'b1};
				end else begin
					vxi_refuse <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Network trigger

	logic trig_pend_r;
	logic [31:0] trig_wait_r;
	logic trig_match;

	// Domain and name filter, either transport
	assign trig_match = trg_valid && (trg_tcp || !trg_tcp) && trg_domain == `LCP_TRIG_DOMAIN &&
		trg_name == FIXED_TRIGGER_NAME;

	// Waits for the output stage, but forces the change before the deadline
	always_ff @(posedge clk) begin
		if (!rstn) begin
			trig_pend_r <= 1'b0;
			trig_wait_r <= 32'h0;
			trig_fire <= 1'b0;
		end else begin
			trig_fire <= 1'b0;
			if (trig_pend_r) begin
				trig_wait_r <= trig_wait_r + 32'h1;
				if (out_ready || trig_wait_r >= 32'(TRIG_DEADLINE_CYC - 2)) begin
					trig_fire <= 1'b1;
					trig_pend_r <= 1'b0;
				end
			end else if ((trig_match && trg_armed) || |code_trig) begin
				trig_pend_r <= 1'b1;
				trig_wait_r <= 32'h0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Discovery answers

	// Only GETPORT is served, over UDP broadcast or TCP alike
	always_ff @(posedge clk) begin
		if (!rstn) begin
			rpc_done <= 1'b0;
			rpc_ok <= 1'b0;
			rpc_tcp_ans <= 1'b0;
			rpc_port <= 16'h0000;
		end else begin
			rpc_done <= rpc_valid;
			if (rpc_valid) begin
				rpc_tcp_ans <= rpc_tcp;
				rpc_ok <= rpc_proc == `LCP_RPC_GETPORT;
				rpc_port <= (rpc_proc == `LCP_RPC_GETPORT && rpc_prog == CORE_PROG) ? `LCP_NUM_VXI_LISTEN : 16'h0000;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Standard event status and enable

	logic [7:0] esr_r;
	logic [7:0] ese_r;
	logic opc_wait_r;
	logic pon_done_r;
	logic [7:0] err_set;

	// Error code range to event bit
	always_comb begin
		err_set = 8'h00;
		if (err_valid) begin
			if (err_code >= `LCP_ERR_100 && err_code < `LCP_ERR_200) err_set[`LCP_BIT_CME] = 1'b1;
			if (err_code >= `LCP_ERR_200 && err_code < `LCP_ERR_300) err_set[`LCP_BIT_EXE] = 1'b1;
			if (err_code >= `LCP_ERR_300 && err_code < `LCP_ERR_400) err_set[`LCP_BIT_DDE] = 1'b1;
			if (err_code >= `LCP_ERR_400 && err_code < `LCP_ERR_500) err_set[`LCP_BIT_QUE] = 1'b1;
		end
		if (opc_wait_r && !ops_busy) err_set[`LCP_BIT_OPC] = 1'b1;
		if (!pon_done_r) err_set[`LCP_BIT_PON] = 1'b1;
	end

	// Operation complete waits in the background; later commands run on
	always_ff @(posedge clk) begin
		if (!rstn) begin
			opc_wait_r <= 1'b0;
			pon_done_r <= 1'b0;
		end else begin
			pon_done_r <= 1'b1;
			if (st_cmd.valid && st_cmd.op == lcp_pkg::ST_OPC) begin
				opc_wait_r <= 1'b1;
			end else if (!ops_busy || (st_cmd.valid && st_cmd.op == lcp_pkg::ST_CLS)) begin
				opc_wait_r <= 1'b0;
			end
		end
	end

	// Event latch; a new event in the clearing cycle survives the clear
	always_ff @(posedge clk) begin
		if (!rstn) begin
			esr_r <= 8'h00;
		end else if (st_cmd.valid && (st_cmd.op == lcp_pkg::ST_CLS || st_cmd.op == lcp_pkg::ST_ESR_RD)) begin
			esr_r <= err_set & `LCP_EVT_USED;
		end else begin
			esr_r <= (esr_r | err_set) & `LCP_EVT_USED;
		end
	end

	// Enable mask; clear status leaves it alone
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ese_r <= `LCP_ESE_RESET;
		end else if (st_cmd.valid && st_cmd.op == lcp_pkg::ST_ESE_WR) begin
			ese_r <= st_cmd.data & `LCP_EVT_USED;
		end
	end

	// Query answers, summary bit and clear-status pulse to the other status sets
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_rsp_valid <= 1'b0;
			st_rsp_data <= 8'h00;
			event_summary_bit <= 1'b0;
			cls_pulse <= 1'b0;
		end else begin
			st_rsp_valid <= st_cmd.valid && (st_cmd.op == lcp_pkg::ST_ESE_RD || st_cmd.op == lcp_pkg::ST_ESR_RD);
			if (st_cmd.valid && st_cmd.op == lcp_pkg::ST_ESE_RD) st_rsp_data <= ese_r;
			if (st_cmd.valid && st_cmd.op == lcp_pkg::ST_ESR_RD) st_rsp_data <= esr_r;
			event_summary_bit <= |(esr_r & ese_r);
			cls_pulse <= st_cmd.valid && st_cmd.op == lcp_pkg::ST_CLS;
		end
	end

endmodule : lcp_top

/* File: shared/lcp_params.svh */
// Constants for the network command port and event status front end.
// Assumes inclusion by bare name from the package and the top module.
`ifndef LCP_PARAMS_SVH
`define LCP_PARAMS_SVH
// In-band control codes and line terminators on the command ports
`define LCP_CODE_CLOSE 8'h01
`define LCP_CODE_TRIG 8'h02
`define LCP_CODE_CLEAR 8'h03
`define LCP_CODE_ENQ 8'h05
`define LCP_CODE_LF 8'h0A
`define LCP_CODE_CR 8'h0D
`define LCP_CODE_LOCK 8'h12
`define LCP_CODE_UNLOCK 8'h14
// Port indices of the three command ports, and the no-owner lock value
`define LCP_PORT_TELNET 2'h0
`define LCP_PORT_RAW 2'h1
`define LCP_PORT_VXI 2'h2
`define LCP_OWNER_NONE 2'h3
// Network port numbers
`define LCP_NUM_VXI_LISTEN 16'h0400
// Event register layout and reset value
`define LCP_BIT_PON 7
`define LCP_BIT_CME 5
`define LCP_BIT_EXE 4
`define LCP_BIT_DDE 3
`define LCP_BIT_QUE 2
`define LCP_BIT_OPC 0
`define LCP_EVT_USED 8'hBD
`define LCP_ESE_RESET 8'h00
// Error code ranges
`define LCP_ERR_100 10'h064
`define LCP_ERR_200 10'h0C8
`define LCP_ERR_300 10'h12C
`define LCP_ERR_400 10'h190
`define LCP_ERR_500 10'h1F4
// Discovery procedure and trigger domain
`define LCP_RPC_GETPORT 8'h03
`define LCP_TRIG_DOMAIN 8'h01
// Trigger deadline, microseconds, and clock rate in MHz
`define LCP_TRIG_DEADLINE_US 2500
`define LCP_CLK_MHZ 200
`endif

/* File: shared/lcp_pkg.sv */
// Types shared by the command port front end and its bench.
// Assumes lcp_params.svh sits in the include path.
package lcp_pkg;
	`include "lcp_params.svh"
	// One received or echoed character
	typedef struct packed {
		logic valid;
		logic [7:0] data;
	} lcp_char_t;
	// Canned answers on a command port
	typedef enum logic [2:0] {
		RSP_NONE = 3'b000,
		RSP_TRIG_ACK = 3'b001,
		RSP_CLEAR_ACK = 3'b010,
		RSP_DESCR = 3'b011,
		RSP_DENIED = 3'b100,
		RSP_GRANTED = 3'b101,
		RSP_PROMPT = 3'b110
	} lcp_rsp_t;
	// Status commands and queries
	typedef enum logic [2:0] {
		ST_ESE_WR = 3'b000,
		ST_ESE_RD = 3'b001,
		ST_ESR_RD = 3'b010,
		ST_CLS = 3'b011,
		ST_OPC = 3'b100
	} lcp_st_op_t;
	typedef struct packed {
		logic valid;
		lcp_st_op_t op;
		logic [7:0] data;
	} lcp_st_cmd_t;
endpackage : lcp_pkg

/* File: test/lcp_host_model.sv */
// Network host model: sends characters on the three command ports.
// Assumes the bench calls send and checks answers just after it returns.
`timescale 1ns/1ps
module lcp_host_model (
	input wire logic clk,
	output lcp_pkg::lcp_char_t [2:0] rx_char
);
	initial rx_char = '0;
	// One char per call; gap models a slow host, lines end in CR or LF
	task automatic send(input int p, input logic [7:0] c, input int gap);
		repeat (gap) @(posedge clk);
		@(posedge clk);
		rx_char[p] <= '{1'b1, c};
		@(posedge clk);
		rx_char[p] <= '{1'b0, ~c}; // Stale byte inverted so it never reads as valid data
	endtask : send
endmodule : lcp_host_model

/* File: test/lcp_monitor.sv */
// Assertion checker for the command port front end, bound into lcp_top.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lcp_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire lcp_pkg::lcp_char_t [2:0] rx_char,
	input wire lcp_pkg::lcp_char_t [2:0] echo_char,
	input wire logic [2:0] line_end,
	input wire lcp_pkg::lcp_rsp_t [2:0] rsp_code,
	input wire logic [2:0] drop_conn,
	input wire logic [1:0] lock_owner,
	input wire logic web_refuse,
	input wire logic vxi_listen,
	input wire logic vxi_accept,
	input wire logic [15:0] vxi_core_port,
	input wire logic [15:0] vxi_async_port,
	input wire logic trig_fire,
	input wire logic rpc_valid,
	input wire logic [7:0] rpc_proc,
	input wire logic rpc_done,
	input wire logic rpc_ok,
	input wire lcp_pkg::lcp_st_cmd_t st_cmd,
	input wire logic cls_pulse
);
	// Reset gates everything; outputs are all idle while it is held
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	////////////////////////////////////////
	// Port behaviour tied to its cause, with exact delays
	a_listen_open: assert property ($past(rstn) |-> vxi_listen)
		else $error("listening port closed");
	a_raw_silent: assert property (!echo_char[1].valid && rsp_code[1] != lcp_pkg::RSP_PROMPT)
		else $error("raw port echoed or prompted");
	a_line_end: assert property (rx_char[1].valid && rx_char[1].data inside {8'h0A, 8'h0D} |=> line_end[1])
		else $error("terminator not flagged");
	a_trig_ack: assert property (rx_char[0].valid && rx_char[0].data == 8'h02 |=> rsp_code[0] == lcp_pkg::RSP_TRIG_ACK)
		else $error("trigger code not acknowledged");
	a_close_drop: assert property (rx_char[0].valid && rx_char[0].data == 8'h01 |=> drop_conn[0])
		else $error("close code did not drop");
	a_grant_owner: assert property (rsp_code[0] == lcp_pkg::RSP_GRANTED |-> lock_owner == 2'h0)
		else $error("granted without ownership");
	a_vxi_ports: assert property (vxi_accept |-> vxi_async_port == vxi_core_port + 16'h0001)
		else $error("session ports not paired");
	a_rpc_answer: assert property (rpc_valid |=> rpc_done && (rpc_ok == ($past(rpc_proc) == 8'h03)))
		else $error("discovery answer wrong");
	a_cls_pulse: assert property (st_cmd.valid && st_cmd.op == lcp_pkg::ST_CLS |=> cls_pulse)
		else $error("clear status not signalled");
	// Main scenarios reached
	c_refuse: cover property (web_refuse);
	c_denied: cover property (rsp_code[1] == lcp_pkg::RSP_DENIED);
	c_fire: cover property (trig_fire);
endmodule : lcp_monitor

bind lcp_top lcp_monitor u_lcp_monitor (.clk, .rstn, .rx_char, .echo_char, .line_end, .rsp_code, .drop_conn,
	.lock_owner, .web_refuse, .vxi_listen, .vxi_accept, .vxi_core_port, .vxi_async_port, .trig_fire,
	.rpc_valid, .rpc_proc, .rpc_done, .rpc_ok, .st_cmd, .cls_pulse);

/* File: test/lcp_top_bench.sv */
// Self-checking bench for lcp_top, with a model of the event registers.
// Assumes lcp_pkg is compiled first and the host model drives the command ports.
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module lcp_top_bench;
	localparam logic [15:0] VXI_BASE = 16'h0800;
	localparam logic [31:0] TNAME = 32'h00005A5A;
	localparam logic [31:0] PROG = 32'h00000007; // arbitrary program number
	localparam int DEADLINE = 20;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [10:0] pul = '0;
	logic [47:0] pay = '0;
	logic trg_armed = 1'b0;
	logic out_ready = 1'b0;
	logic ops_busy = 1'b0;
	lcp_pkg::lcp_st_cmd_t st_cmd = '0;
	lcp_pkg::lcp_char_t [2:0] rx_char, echo_char, parse_char;
	lcp_pkg::lcp_rsp_t [2:0] rsp_code;
	logic [2:0] line_end, drop_conn, ctl_ok;
	logic dev_clear;
	logic [1:0] lock_owner;
	logic web_accept, web_refuse, vxi_listen, vxi_accept, vxi_refuse, trig_fire, rpc_done, rpc_ok, rpc_tcp_ans;
	logic [15:0] vxi_core_port, vxi_async_port, rpc_port;
	logic st_rsp_valid, event_summary_bit, cls_pulse;
	logic [7:0] st_rsp_data, q, d;
	logic [7:0] codes [3] = '{8'h02, 8'h03, 8'h05};
	lcp_pkg::lcp_rsp_t rsps [3] = '{lcp_pkg::RSP_TRIG_ACK, lcp_pkg::RSP_CLEAR_ACK, lcp_pkg::RSP_DESCR};
	int fail_count, num_checks, esr_m, ese_m, n;

	// Short deadline keeps the slow-output trigger case brief
	lcp_top #(.VXI_PORT_BASE(VXI_BASE), .FIXED_TRIGGER_NAME(TNAME), .CORE_PROG(PROG),
		.TRIG_DEADLINE_CYC(DEADLINE)) dut (
		.clk, .rstn, .rx_char, .conn_open(pul[7:5]), .conn_close(pul[10:8]), .vxi_sess(1'b0),
		.echo_char, .parse_char, .line_end, .rsp_code, .drop_conn, .lock_owner, .ctl_ok, .dev_clear,
		.web_open(pul[0]), .web_close(1'b0), .web_accept, .web_refuse, .vxi_open(pul[1]), .vxi_close(1'b0),
		.vxi_close_sess(1'b0), .vxi_listen, .vxi_accept, .vxi_refuse, .vxi_new_sess(), .vxi_core_port,
		.vxi_async_port, .trg_valid(pul[2]), .trg_tcp(pay[40]), .trg_domain(pay[39:32]), .trg_name(pay[31:0]),
		.trg_armed, .out_ready, .trig_fire, .rpc_valid(pul[3]), .rpc_tcp(pay[40]), .rpc_proc(pay[39:32]),
		.rpc_prog(pay[31:0]), .rpc_done, .rpc_ok, .rpc_tcp_ans, .rpc_port, .st_cmd, .err_valid(pul[4]),
		.err_code(pay[9:0]), .ops_busy, .st_rsp_valid, .st_rsp_data, .event_summary_bit, .cls_pulse);
	lcp_host_model host (.clk, .rx_char);

	// 200 MHz clock
	always #2.5 clk = ~clk;
	////////////////////////////////////////
	// One-cycle strobe with its payload; returns just after the answer edge
	task automatic fire(input int b, input logic [47:0] p);
		@(posedge clk);
		pul[b] <= 1'b1;
		pay <= p;
		@(posedge clk);
		pul[b] <= 1'b0;
		#1;
	endtask : fire
	task automatic st(input lcp_pkg::lcp_st_op_t op, input logic [7:0] v, output logic [7:0] r);
		@(posedge clk);
		st_cmd <= '{1'b1, op, v};
		@(posedge clk);
		st_cmd <= '0;
		#1;
		r = st_rsp_data;
	endtask : st
	// Register query against the model; an event read empties the model too
	task automatic rd(input lcp_pkg::lcp_st_op_t op);
		st(op, 8'h00, q);
		`CHK(st_rsp_valid, 1'b1)
		`CHK(q, 8'(op == lcp_pkg::ST_ESE_RD ? ese_m : esr_m))
		if (op == lcp_pkg::ST_ESR_RD) esr_m = 0;
	endtask : rd
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////
	// Main sequence
	initial begin
		void'($urandom(8));
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		#1;
		`CHK(lock_owner, 2'h3)
		esr_m = 8'h80;
		ese_m = 0;
		rd(lcp_pkg::ST_ESE_RD);
		rd(lcp_pkg::ST_ESR_RD);
		rd(lcp_pkg::ST_ESR_RD);
		for (int i = 0; i < 4; i++) begin
			d = (i == 0) ? 8'hFF : 8'($urandom_range(0, 255));
			st(lcp_pkg::ST_ESE_WR, d, q);
			ese_m = d & 8'hBD;
			rd(lcp_pkg::ST_ESE_RD);
		end
		// Summary lags the event bit by one cycle, so look two edges on
		for (int k = 1; k <= 4; k++) begin
			fire(4, 48'(100 * k + $urandom_range(0, 99)));
			esr_m |= 1 << (6 - k);
			repeat (2) @(posedge clk);
			#1;
			`CHK(event_summary_bit, |(8'(esr_m) & 8'(ese_m)))
		end
		rd(lcp_pkg::ST_ESR_RD);
		fire(4, 48'd250);
		st(lcp_pkg::ST_CLS, 8'h00, q);
		`CHK(cls_pulse, 1'b1)
		rd(lcp_pkg::ST_ESR_RD);
		rd(lcp_pkg::ST_ESE_RD);
		@(posedge clk);
		ops_busy <= 1'b1;
		st(lcp_pkg::ST_OPC, 8'h00, q);
		repeat (4) @(posedge clk);
		rd(lcp_pkg::ST_ESR_RD);
		ops_busy <= 1'b0;
		repeat (3) @(posedge clk);
		esr_m = 1;
		rd(lcp_pkg::ST_ESR_RD);
		// Command ports: echo, terminators, control codes, lock
		out_ready <= 1'b1;
		fire(5, 48'h0);
		host.send(0, 8'h41, 0);
		#1;
		`CHK(echo_char[0], {1'b1, 8'h41})
		`CHK(parse_char[0].valid, 1'b1)
		host.send(1, 8'h41, 2);
		#1;
		`CHK(echo_char[1].valid, 1'b0)
		host.send(0, 8'h0D, 0);
		#1;
		`CHK(line_end, 3'b001)
		`CHK(rsp_code[0], lcp_pkg::RSP_PROMPT)
		host.send(1, 8'h0A, 1);
		#1;
		`CHK(line_end, 3'b010)
		`CHK(rsp_code[1], lcp_pkg::RSP_NONE)
		for (int i = 0; i < 6; i++) begin
			host.send(i % 2, codes[i / 2], i);
			#1;
			`CHK(rsp_code[i % 2], rsps[i / 2])
			`CHK(dev_clear, 1'(codes[i / 2] == 8'h03))
		end
		host.send(0, 8'h12, 2);
		#1;
		`CHK(rsp_code[0], lcp_pkg::RSP_GRANTED)
		`CHK(lock_owner, 2'h0)
		fire(6, 48'h0);
		host.send(1, 8'h12, 0);
		#1;
		`CHK(rsp_code[1], lcp_pkg::RSP_DENIED)
		`CHK(ctl_ok, 3'b001)
		host.send(0, 8'h14, 0);
		#1;
		`CHK(lock_owner, 2'h3)
		host.send(0, 8'h12, 0);
		#1;
		`CHK(rsp_code[0], lcp_pkg::RSP_DENIED)
		fire(9, 48'h0);
		host.send(0, 8'h12, 0);
		#1;
		`CHK(rsp_code[0], lcp_pkg::RSP_GRANTED)
		host.send(0, 8'h01, 0);
		#1;
		`CHK(drop_conn, 3'b001)
		repeat (2) @(posedge clk);
		#1;
		`CHK(lock_owner, 2'h3)
		// Connection limits and session ports
		for (int i = 0; i < 9; i++) begin
			fire(0, 48'h0);
			`CHK(web_accept, 1'(i < 8))
			`CHK(web_refuse, 1'(i == 8))
		end
		for (int i = 0; i < 3; i++) begin
			fire(1, 48'h0);
			`CHK(vxi_accept, 1'(i < 2))
			`CHK(vxi_refuse, 1'(i == 2))
			if (i < 2) `CHK(vxi_core_port, VXI_BASE + 16'(2 * i))
		end
		// Triggers: ready, slow output, wrong domain, wrong name, disarmed
		for (int i = 0; i < 5; i++) begin
			@(posedge clk);
			out_ready <= (i != 1);
			trg_armed <= (i != 4);
			fire(2, {7'h00, 1'(i), (i == 2) ? 8'h02 : 8'h01, (i == 3) ? ~TNAME : TNAME});
			n = 0;
			while (trig_fire !== 1'b1 && n < 30) begin
				@(posedge clk);
				#1;
				n++;
			end
			`CHK(n < 30, i < 2)
			if (i == 0) `CHK(n, 1)
			if (i == 1) `CHK(n <= DEADLINE, 1'b1)
		end
		// Discovery over both transports, one unsupported procedure random
		for (int i = 0; i < 4; i++) begin
			d = (i == 3) ? 8'($urandom_range(4, 255)) : ((i == 1) ? 8'h04 : 8'h03);
			fire(3, {7'h00, 1'(i % 2), d, (i == 2) ? PROG + 1 : PROG});
			`CHK(rpc_done, 1'b1)
			`CHK(rpc_ok, 1'(d == 8'h03))
			`CHK(rpc_tcp_ans, 1'(i % 2))
			if (d == 8'h03) `CHK(rpc_port, (i == 2) ? 16'h0000 : 16'h0400)
		end
		finish_test();
	end

	// Hang guard, far above the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fail_count++;
		finish_test();
	end
endmodule : lcp_top_bench
